// ==== hw/msi_pkg.sv ====
// Constants for the module status indicator block.
// Assumes a 40 MHz system clock and an APB register master.
package msi_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned SEARCH_HI_MS  = 200;
  localparam int unsigned SEARCH_LO_MS  = 1800;
  localparam int unsigned IDLE_HI_MS    = 234;
  localparam int unsigned IDLE_LO_MS    = 266;
  localparam int unsigned DATA_LO_MS    = 63;
  localparam int unsigned DATA_HI_MS    = 62;
  localparam int unsigned RING_LOW_MS   = 120;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_URC     = 8'h14;
  localparam logic [7:0] ADDR_WAKE    = 8'h18;

  // CTRL fields.
  localparam int unsigned CTRL_NET_LSB   = 0;
  localparam int unsigned CTRL_FUN_LSB   = 4;
  localparam int unsigned CTRL_SLEEP_LSB = 8;
  localparam int unsigned CTRL_RTE_LSB   = 12;
  localparam int unsigned CTRL_AIRHW_BIT = 16;
  localparam int unsigned CTRL_PWR_BIT   = 17;

  // CTRL field encodings.
  localparam logic [2:0]  FUN_MIN      = 3'h0;
  localparam logic [2:0]  FUN_FULL     = 3'h1;
  localparam logic [2:0]  FUN_AIR      = 3'h4;
  localparam logic [1:0]  SLEEP_PSM    = 2'h3;
  localparam logic [1:0]  ROUTE_UART   = 2'h0;
  localparam logic [1:0]  ROUTE_USBAT  = 2'h1;
  localparam logic [1:0]  ROUTE_MODEM  = 2'h2;

  // Network states written by software.
  localparam logic [1:0]  NET_SEARCH = 2'h0;
  localparam logic [1:0]  NET_IDLE   = 2'h1;
  localparam logic [1:0]  NET_DATA   = 2'h2;
  localparam logic [1:0]  NET_VOICE  = 2'h3;

  // Interrupt events.
  localparam int unsigned IRQ_URC  = 0;
  localparam int unsigned IRQ_AIR  = 1;
  localparam int unsigned IRQ_WAKE = 2;
  localparam int unsigned IRQ_W    = 3;

  typedef enum logic [1:0] {
    MSI_AWAKE = 2'b01,
    MSI_PSM   = 2'b10
  } msi_pwr_t;

endpackage : msi_pkg

// ==== hw/msi_top.sv ====
// Status and control signalling logic of a cellular module.
// Assumes an APB master on clk_i and host pins synchronous to clk_i.
//
// Summary of operation
// - Searching: network LED 200 ms high, 1800 ms low, repeating.
// - Idle: network LED 234 ms high, 266 ms low, repeating.
// - Data: 63 ms low, 62 ms high; voice call: held high.
// - Operation status released high only after power-on completes.
// - Ring indicator rests high while no result is pending.
// - Each new unsolicited result starts or restarts a 120 ms low pulse.
// - Ring pulse fires whatever port the result is routed to.
// - Result routing defaults to USB command port; UART or modem selectable.
// - Airplane request low enters airplane mode when hardware control enabled.
// - Hardware airplane control is off after reset until set to 1.
// - Functionality levels 0 minimum, 1 full default, 4 airplane.
// - Sleep ends on wake input high or wake timer expiry.
// - Sleep indicator output shows power-saving mode.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module msi_top
  import msi_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        airplane_req_n_i,
  input  wire logic        sleep_wake_input_i,
  input  wire logic        host_processor_ready_i,
  output logic             network_activity_led_o,
  output logic             status_oe_o,
  output logic             status_o,
  output logic             ring_indicator_out_o,
  output logic             sleep_state_indicator_o,
  output logic [1:0]       urc_port_o,
  output logic             rf_enable_o,
  output logic             irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [1:0]  net_ff, nxt_net;
  logic [2:0]  fun_ff, nxt_fun;
  logic [1:0]  sleep_ff, nxt_sleep;
  logic [1:0]  route_ff, nxt_route;
  logic        airhw_ff, nxt_airhw;
  logic        pwr_ff, nxt_pwr;
  logic [IRQ_W-1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
  logic [15:0] wake_ff, nxt_wake;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ready_ff, nxt_ready, err_ff, nxt_err;
  logic        urc_evt;
  logic        wr, rd;
  assign wr = psel_i & penable_i & pwrite_i & ~ready_ff;
  assign rd = psel_i & penable_i & ~pwrite_i & ~ready_ff;
  // ****************************************
  // Millisecond tick and pattern timers
  // ****************************************
  logic [31:0] div_ff, nxt_div;
  logic        tick;
  logic [11:0] ms_ff, nxt_ms;
  logic [6:0]  ri_ff, nxt_ri;
  logic [1:0]  net_q_ff, nxt_net_q;
  logic        led_ff, nxt_led;
  msi_pwr_t    pst_ff, nxt_pst;
  logic [15:0] wcnt_ff, nxt_wcnt;
  logic        wake_evt;
  logic        air_ff, nxt_air;
  logic        air_on;
  assign tick = (div_ff == TICK_DIV - 1);
  always_comb begin
    logic [11:0] hi_ms;
    logic [11:0] per_ms;
    logic        hi_first;
    hi_ms    = 12'h0;
    per_ms   = 12'h1;
    hi_first = 1'b1;
    nxt_div  = tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
    nxt_ms   = ms_ff;
    nxt_net_q = net_ff;
    unique case (net_ff)
      NET_SEARCH: begin
        hi_ms  = 12'(SEARCH_HI_MS);
        per_ms = 12'(SEARCH_HI_MS + SEARCH_LO_MS);
      end
      NET_IDLE: begin
        hi_ms  = 12'(IDLE_HI_MS);
        per_ms = 12'(IDLE_HI_MS + IDLE_LO_MS);
      end
      NET_DATA: begin
        hi_ms    = 12'(DATA_LO_MS);
        per_ms   = 12'(DATA_LO_MS + DATA_HI_MS);
        hi_first = 1'b0;
      end
      NET_VOICE: begin
        hi_ms  = 12'(1);
        per_ms = 12'(1);
      end
    endcase
    if (net_ff != net_q_ff) begin
      nxt_ms = 12'h000;
    end else if (tick) begin
      nxt_ms = (ms_ff + 12'h001 >= per_ms) ? 12'h000 : ms_ff + 12'h001;
    end
    if (net_ff == NET_VOICE) begin
      nxt_led = 1'b1;
    end else begin
      nxt_led = ((nxt_ms < hi_ms) == hi_first);
    end
  end

  // ****************************************
  // Ring indicator, power state, airplane
  // ****************************************
  assign urc_evt  = wr & (paddr_i == ADDR_URC) & pwdata_i[0];
  assign wake_evt = (pst_ff == MSI_PSM) &
                    (sleep_wake_input_i | (wcnt_ff == 16'h0000));
  assign air_on = airhw_ff & ~airplane_req_n_i;
  always_comb begin
    nxt_ri = ri_ff;
    if (urc_evt) begin
      nxt_ri = 7'(RING_LOW_MS);
    end else if (tick && ri_ff != 7'h00) begin
      nxt_ri = ri_ff - 7'h01;
    end
    nxt_air  = air_on;
    nxt_pst  = pst_ff;
    nxt_wcnt = wcnt_ff;
    unique case (pst_ff)
      MSI_AWAKE: begin
        if (sleep_ff == SLEEP_PSM && fun_ff == FUN_FULL && pwr_ff
            && wake_ff != 16'h0000) begin
          nxt_pst  = MSI_PSM;
          nxt_wcnt = wake_ff;
        end
      end
      MSI_PSM: begin
        if (wake_evt) begin
          nxt_pst = MSI_AWAKE;
        end else if (tick) begin
          nxt_wcnt = wcnt_ff - 16'h0001;
        end
      end
    endcase
  end

  // ****************************************
  // APB register file
  // ****************************************
  always_comb begin
    nxt_net   = net_ff;
    nxt_fun   = fun_ff;
    nxt_sleep = sleep_ff;
    nxt_route = route_ff;
    nxt_airhw = airhw_ff;
    nxt_pwr   = pwr_ff;
    nxt_ien   = ien_ff;
    nxt_wake  = wake_ff;
    nxt_ist   = ist_ff;
    nxt_rdata = rdata_ff;
    nxt_ready = 1'b0;
    nxt_err   = 1'b0;
    if (wr) begin
      nxt_ready = 1'b1;
      unique case (paddr_i)
        ADDR_CTRL: begin
          nxt_net   = pwdata_i[CTRL_NET_LSB +: 2];
          // Only levels 0, 1 and 4 accepted.
          if (pwdata_i[CTRL_FUN_LSB +: 3] == FUN_MIN ||
              pwdata_i[CTRL_FUN_LSB +: 3] == FUN_FULL ||
              pwdata_i[CTRL_FUN_LSB +: 3] == FUN_AIR) begin
            nxt_fun = pwdata_i[CTRL_FUN_LSB +: 3];
          end
          // Sleep value only taken in airplane level.
          if (fun_ff == FUN_AIR) begin
            nxt_sleep = pwdata_i[CTRL_SLEEP_LSB +: 2];
          end
          if (pwdata_i[CTRL_RTE_LSB +: 2] != 2'h3) begin
            nxt_route = pwdata_i[CTRL_RTE_LSB +: 2];
          end
          nxt_airhw = pwdata_i[CTRL_AIRHW_BIT];
          nxt_pwr   = pwdata_i[CTRL_PWR_BIT];
        end
        ADDR_IRQ_EN:  nxt_ien  = pwdata_i[IRQ_W-1:0];
        ADDR_IRQ_CLR: nxt_ist  = ist_ff & ~pwdata_i[IRQ_W-1:0];
        ADDR_WAKE:    nxt_wake = pwdata_i[15:0];
        ADDR_URC:     nxt_ist  = ist_ff;
        default:      nxt_err  = 1'b1;
      endcase
    end else if (rd) begin
      nxt_ready = 1'b1;
      unique case (paddr_i)
        ADDR_CTRL: nxt_rdata = {14'h0, pwr_ff, airhw_ff, 2'h0, route_ff,
                                2'h0, sleep_ff, 1'b0, fun_ff, 2'h0, net_ff};
        ADDR_STATUS: nxt_rdata = {26'h0, host_processor_ready_i,
                                  air_ff, pst_ff == MSI_PSM,
                                  ri_ff != 7'h00, led_ff, pwr_ff};
        ADDR_IRQ_ST: nxt_rdata = {29'h0, ist_ff};
        ADDR_IRQ_EN: nxt_rdata = {29'h0, ien_ff};
        ADDR_WAKE:   nxt_rdata = {16'h0000, wake_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_err   = 1'b1;
        end
      endcase
    end
    // Events set after the clear, so a set wins.
    if (urc_evt) begin
      nxt_ist[IRQ_URC] = 1'b1;
    end
    if (air_on & ~air_ff) begin
      nxt_ist[IRQ_AIR] = 1'b1;
    end
    if (wake_evt) begin
      nxt_ist[IRQ_WAKE] = 1'b1;
      nxt_sleep         = 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      net_ff   <= NET_SEARCH;
      fun_ff   <= FUN_FULL;
      sleep_ff <= 2'h0;
      route_ff <= ROUTE_USBAT;
      airhw_ff <= 1'b0;
      pwr_ff   <= 1'b0;
      ien_ff   <= '0;
      ist_ff   <= '0;
      wake_ff  <= 16'h0000;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      div_ff   <= 32'h0000_0000;
      ms_ff    <= 12'h000;
      net_q_ff <= NET_SEARCH;
      led_ff   <= 1'b0;
      ri_ff    <= 7'h00;
      pst_ff   <= MSI_AWAKE;
      wcnt_ff  <= 16'h0000;
      air_ff   <= 1'b0;
    end else if (ce_i) begin
      net_ff   <= nxt_net;
      fun_ff   <= nxt_fun;
      sleep_ff <= nxt_sleep;
      route_ff <= nxt_route;
      airhw_ff <= nxt_airhw;
      pwr_ff   <= nxt_pwr;
      ien_ff   <= nxt_ien;
      ist_ff   <= nxt_ist;
      wake_ff  <= nxt_wake;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff   <= nxt_err;
      div_ff   <= nxt_div;
      ms_ff    <= nxt_ms;
      net_q_ff <= nxt_net_q;
      led_ff   <= nxt_led;
      ri_ff    <= nxt_ri;
      pst_ff   <= nxt_pst;
      wcnt_ff  <= nxt_wcnt;
      air_ff   <= nxt_air;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic irq_ff, rf_ff, ring_ff, slp_ff, stoe_ff;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_ff  <= 1'b0;
      rf_ff   <= 1'b0;
      ring_ff <= 1'b1;
      slp_ff  <= 1'b0;
      stoe_ff <= 1'b1;
    end else if (ce_i) begin
      irq_ff  <= |(nxt_ist & nxt_ien);
      rf_ff   <= (nxt_fun == FUN_FULL) & ~nxt_air & (nxt_pst == MSI_AWAKE);
      ring_ff <= (nxt_ri == 7'h00);
      slp_ff  <= (nxt_pst == MSI_PSM);
      stoe_ff <= ~nxt_pwr;
    end
  end

  assign prdata_o  = rdata_ff;
  assign pready_o  = ready_ff;
  assign pslverr_o = err_ff;
  assign network_activity_led_o = led_ff;
  // Open drain released high once powered on.
  assign status_oe_o = stoe_ff;
  assign status_o    = 1'b0;
  assign ring_indicator_out_o = ring_ff;
  assign sleep_state_indicator_o = slp_ff;
  // Routing does not gate the ring pulse.
  assign urc_port_o  = route_ff;
  assign rf_enable_o = rf_ff;
  assign irq_o       = irq_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_VOICE_HIGH: assert property (
    ce_i && net_ff == NET_VOICE && net_q_ff == NET_VOICE |=> led_ff)
    else $error("Voice state led not high.");
  AST_RING_PULSE: assert property (
    urc_evt && ce_i |=> !ring_indicator_out_o)
    else $error("Ring pulse did not start.");
  AST_RING_IDLE: assert property (
    ri_ff == 7'h00 |-> ring_indicator_out_o)
    else $error("Ring output low while idle.");
  AST_STATUS_PWR: assert property (
    !pwr_ff |-> status_oe_o && !status_o)
    else $error("Status released before power on.");
  AST_AIR_OFF: assert property (
    ce_i && !airhw_ff |=> !air_ff)
    else $error("Airplane pin acted while disabled.");
  AST_AIR_ON: assert property (
    ce_i && airhw_ff && !airplane_req_n_i |=> air_ff)
    else $error("Airplane request missed.");
  AST_FUN_LEGAL: assert property (
    fun_ff == FUN_MIN || fun_ff == FUN_FULL || fun_ff == FUN_AIR)
    else $error("Illegal functionality level.");
  AST_WAKE: assert property (
    ce_i && pst_ff == MSI_PSM && sleep_wake_input_i |=> pst_ff == MSI_AWAKE)
    else $error("Wake input did not end sleep.");
  AST_IND: assert property (
    sleep_state_indicator_o == (pst_ff == MSI_PSM))
    else $error("Sleep indicator mismatch.");
  AST_ROUTE: assert property (
    route_ff != 2'h3)
    else $error("Illegal route.");

  COV_URC:   cover property (urc_evt ##1 !ring_indicator_out_o);
  COV_PSM:   cover property (pst_ff == MSI_AWAKE ##1 pst_ff == MSI_PSM);
  COV_AIR:   cover property (air_on);
  COV_PHASE: cover property (net_ff != net_q_ff);

endmodule : msi_top

`default_nettype wire

// ==== sim/msi_host_model.sv ====
// Host processor pin model facing the status indicator block.
// Assumes bench commands that change only after rising clock edges.
`timescale 1ns/10ps
`default_nettype none

module msi_host_model (
  input  wire logic air_cmd_i,
  input  wire logic wake_cmd_i,
  input  wire logic rdy_cmd_i,
  input  wire logic status_oe_i,
  output logic      airplane_req_n_o,
  output logic      wake_o,
  output logic      ready_o,
  output logic      status_pin_o
);
  // ****************************************
  // Host pins
  // ****************************************
  // Pulled up default.
  assign airplane_req_n_o = air_cmd_i ? 1'b0 : 1'b1;
  assign wake_o = wake_cmd_i;
  assign ready_o = rdy_cmd_i;
  assign status_pin_o = status_oe_i ? 1'b0 : 1'b1;
endmodule : msi_host_model

`default_nettype wire

// ==== sim/msi_top_tb.sv ====
// Self-checking bench of the status indicator block.
// Assumes the host pin model and a shortened millisecond tick.
`timescale 1ns/10ps
`default_nettype none

module msi_top_tb;
  import msi_pkg::*;
  localparam int unsigned DIV = 10;
  logic        clk_i, reset_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, ctrl, lfsr;
  logic        pready_o, pslverr_o, air_n, wake, rdy, led, st_oe, st_o;
  logic        ri, slp, rf, irq, air_cmd, wake_cmd, rdy_cmd, st_pin;
  logic [1:0]  urc;
  int          bad_count, n_tests, n, t, r0;

  msi_top #(.TICK_DIV(DIV)) i_msi_top (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .airplane_req_n_i(air_n),
    .sleep_wake_input_i(wake), .host_processor_ready_i(rdy),
    .network_activity_led_o(led), .status_oe_o(st_oe), .status_o(st_o),
    .ring_indicator_out_o(ri), .sleep_state_indicator_o(slp),
    .urc_port_o(urc), .rf_enable_o(rf), .irq_o(irq));

  msi_host_model i_msi_host_model (
    .air_cmd_i(air_cmd), .wake_cmd_i(wake_cmd), .rdy_cmd_i(rdy_cmd),
    .status_oe_i(st_oe), .airplane_req_n_o(air_n), .wake_o(wake),
    .ready_o(rdy), .status_pin_o(st_pin));

  // ****************************************
  // Helpers
  // ****************************************
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic sig(input int s);
    if (s == 0) return led;
    if (s == 1) return ri;
    return slp;
  endfunction : sig

  task summarize();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task hang();
    bad_count++;
    summarize();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) hang();
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clk_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, {31'h0, xe}, {31'h0, e});
    if (xe === 1'b0) chk(nm, x, r);
  endtask : rdc

  // Count cycles while a watched output stays at one level.
  task automatic run(input int s, input logic lvl, output int c);
    c = 0;
    while (sig(s) === lvl) begin
      @(negedge clk_i);
      c++;
      if (c > 30000) hang();
    end
  endtask : run

  task automatic led_chk(input string nm, input logic f,
                         input int l1, input int l2);
    int c;
    run(0, f, c);
    run(0, !f, c);
    run(0, f, c);
    chk(nm, l1 * DIV, c);
    run(0, !f, c);
    chk(nm, l2 * DIV, c);
  endtask : led_chk

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    {reset_i, ce_i, rdy_cmd} = 3'b111;
    {psel_i, penable_i, pwrite_i, air_cmd, wake_cmd} = 5'b0_0000;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    lfsr = 32'h81ca_58eb;
    ctrl = 32'h0000_0000;
    ctrl[CTRL_FUN_LSB +: 3] = FUN_FULL;
    ctrl[CTRL_RTE_LSB +: 2] = ROUTE_USBAT;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk("ring idle", 1, ri);
    chk("status pin", 0, st_pin);
    chk("route", ROUTE_USBAT, urc);
    chk("sleep ind", 0, slp);
    rdc("ctrl reset", ADDR_CTRL, ctrl, 1'b0);
    rdc("unmapped", 8'h1C, 0, 1'b1);
    rdc("clr read", ADDR_IRQ_CLR, 0, 1'b1);
    ctrl[CTRL_PWR_BIT] = 1'b1;
    wr(ADDR_CTRL, ctrl);
    repeat (3) @(negedge clk_i);
    chk("status pin", 1, st_pin);
    for (int i = 0; i < 3; i++) begin
      ctrl[1:0] = NET_VOICE;
      wr(ADDR_CTRL, ctrl);
      repeat (3 * DIV) @(negedge clk_i);
      chk("voice led", 1, led);
      @(posedge clk_i);
      rdy_cmd <= ~i[0];
      rdc("status", ADDR_STATUS, {26'h0, ~i[0], 5'h03}, 1'b0);
      ctrl[1:0] = i[1:0];
      wr(ADDR_CTRL, ctrl);
      if (i == 0) led_chk("search", 1, SEARCH_HI_MS, SEARCH_LO_MS);
      if (i == 1) led_chk("idle", 1, IDLE_HI_MS, IDLE_LO_MS);
      if (i == 2) led_chk("data", 0, DATA_LO_MS, DATA_HI_MS);
    end
    ctrl[1:0] = NET_IDLE;
    wr(ADDR_CTRL, ctrl);
    run(0, 1, n);
    t = (IDLE_HI_MS - 1) * DIV + 1;
    chk("restart", 1, n >= t && n <= IDLE_HI_MS * DIV);
    r0 = rnd() % 3;
    for (int i = 0; i < 3; i++) begin
      ctrl[CTRL_RTE_LSB +: 2] = 2'((r0 + i) % 3);
      wr(ADDR_CTRL, ctrl);
      chk("route", (r0 + i) % 3, urc);
      wr(ADDR_URC, rnd() | 32'h0000_0001);
      chk("ring low", 0, ri);
      run(1, 0, n);
      t = (RING_LOW_MS - 1) * DIV;
      chk("ring len", 1, n >= t && n <= RING_LOW_MS * DIV);
      chk("ring idle", 1, ri);
    end
    wr(ADDR_CTRL, ctrl | 32'h0000_3000);
    chk("bad route", ctrl[CTRL_RTE_LSB +: 2], urc);
    rdc("irq st", ADDR_IRQ_ST, 32'h0000_0001, 1'b0);
    chk("irq masked", 0, irq);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    chk("irq on", 1, irq);
    wr(ADDR_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    chk("irq clr", 0, irq);
    @(posedge clk_i);
    air_cmd <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("air off", 1, rf);
    ctrl[CTRL_AIRHW_BIT] = 1'b1;
    wr(ADDR_CTRL, ctrl);
    repeat (3) @(negedge clk_i);
    chk("air on", 0, rf);
    rdc("irq air", ADDR_IRQ_ST, 32'h0000_0002, 1'b0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    air_cmd <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("ce hold", 0, rf);
    @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("air rel", 1, rf);
    ctrl[CTRL_FUN_LSB +: 3] = FUN_MIN;
    wr(ADDR_CTRL, ctrl);
    chk("fun min", 0, rf);
    ctrl[CTRL_FUN_LSB +: 3] = FUN_AIR;
    wr(ADDR_CTRL, ctrl);
    wr(ADDR_CTRL, ctrl ^ 32'h0000_0060);
    rdc("bad fun", ADDR_CTRL, ctrl, 1'b0);
    chk("fun air", 0, rf);
    wr(ADDR_IRQ_CLR, 32'h0000_0007);
    for (int j = 0; j < 2; j++) begin
      t = 2 + rnd() % 8;
      wr(ADDR_WAKE, t);
      ctrl[CTRL_FUN_LSB +: 3] = FUN_AIR;
      wr(ADDR_CTRL, ctrl);
      ctrl[CTRL_SLEEP_LSB +: 2] = SLEEP_PSM;
      wr(ADDR_CTRL, ctrl);
      ctrl[CTRL_FUN_LSB +: 3] = FUN_FULL;
      wr(ADDR_CTRL, ctrl);
      chk("sleep ind", 1, slp);
      if (j == 0) begin
        @(posedge clk_i);
        wake_cmd <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk("pin wake", 0, slp);
        rdc("irq wake", ADDR_IRQ_ST, 32'h0000_0004, 1'b0);
        @(posedge clk_i);
        wake_cmd <= 1'b0;
      end else begin
        run(2, 1, n);
        n = n - (t - 1) * DIV;
        chk("timer wake", 1, n >= 2 && n <= DIV + 1);
      end
    end
    summarize();
  end
endmodule : msi_top_tb

`default_nettype wire
